// >>> logic/timer_capture_restart.sv
// 16-bit capture-restart timer with an AXI4-Lite register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Behaviour
// - An accepted input edge copies the count into the capture register.
// - In capture-restart mode the count advances on the prescaled clock.
// - The polarity bit picks rising or falling input edges for capture.
// - A capture raises the interrupt and restarts the count at 0001h.
// - A capture sets the capture-cause flag.
// - Without capture the count rises until it equals the reload value.
// - Reaching reload raises the interrupt and restarts the count at 0001h.
// - A reload without capture clears the capture-cause flag.
// - The source select limits interrupts to captures or reloads only.
// - The count advances once per prescale period of the system clock.
module timer_capture_restart
	import capture_timer_pkg::*;
(
	input  wire logic        aclk,          // System clock, 100 MHz
	input  wire logic        aresetn,       // Synchronous reset, low
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output wire logic        s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output wire logic        s_axi_wready,  // Write data ready
	output logic      [1:0]  s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output wire logic        s_axi_arready, // Read address ready
	output logic      [31:0] s_axi_rdata,   // Read data
	output logic      [1:0]  s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	input  wire logic        timer_in,      // Timer input pin
	output wire logic        irq            // Level interrupt
);
	// ********************
	// Registers
	// ********************
	logic [7:0]  control;
	logic [7:0]  control2;
	logic [15:0] count;
	logic [15:0] reload;
	logic [15:0] capture;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ********************
	// Control decode
	// ********************
	wire       enabled  = control[enable_bit];
	wire [3:0] mode     = {control2[mode_upper_pos],
		control[mode_lsb +: mode_width]};
	wire       cr_mode  = (mode == mode_capture_restart);
	wire       running  = enabled && cr_mode;
	wire [1:0] src_sel  = control2[source_sel_lsb +: 2];
	wire [2:0] pre_sel  = control[prescale_lsb +: prescale_width];

	// ********************
	// Timing events
	// ********************
	wire tick;
	wire edge_seen;
	wire capture_evt;

	edge_detect u_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin        (timer_in),
		.rising     (control[polarity_bit]),
		.edge_pulse (edge_seen)
	);

	prescaler #(.WIDTH(7)) u_pre (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (running),
		// Capture restarts the period so later counts stay exact
		.restart (capture_evt),
		.shift   (pre_sel),
		.tick    (tick)
	);

	assign capture_evt = running && edge_seen;
	wire reload_evt  = running && tick && !capture_evt && (count == reload);
	wire cap_irq_ok  = (src_sel != source_reload);
	wire rel_irq_ok  = (src_sel != source_capture);

	// ********************
	// AXI4-Lite write path
	// ********************
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	wire aw_take  = s_axi_awvalid && s_axi_awready;
	wire w_take   = s_axi_wvalid && s_axi_wready;
	wire have_aw  = aw_held || aw_take;
	wire have_w   = w_held || w_take;
	wire do_write = have_aw && have_w;
	wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_hit = (wr_addr == control_offset) || (wr_addr == control2_offset)
		|| (wr_addr == count_offset) || (wr_addr == reload_offset)
		|| (wr_addr == capture_offset) || (wr_addr == irq_status_offset)
		|| (wr_addr == irq_mask_offset);

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		merge16 = {strb[1] ? data[15:8] : old[15:8],
			strb[0] ? data[7:0] : old[7:0]};
	endfunction : merge16

	wire we_control  = do_write && wr_addr == control_offset && wr_strb[0];
	wire we_control2 = do_write && wr_addr == control2_offset && wr_strb[0];
	wire we_count    = do_write && wr_addr == count_offset;
	wire we_reload   = do_write && wr_addr == reload_offset;
	wire we_status   = do_write && wr_addr == irq_status_offset && wr_strb[0];
	wire we_mask     = do_write && wr_addr == irq_mask_offset && wr_strb[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= axi_okay;
		end
		else
		begin
			if (aw_take && !do_write)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take && !do_write)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? axi_okay : axi_slverr;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ********************
	// Control and configuration
	// ********************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			control  <= 8'h00;
			reload   <= reload_reset;
			irq_mask <= 2'h0;
		end
		else
		begin
			if (we_control)
				control <= wr_data[7:0];
			if (we_reload)
				reload <= merge16(reload, wr_data, wr_strb);
			if (we_mask)
				irq_mask <= wr_data[1:0];
		end
	end

	// Cause flag is hardware owned; software writes other bits only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control2 <= 8'h00;
		else
		begin
			if (we_control2)
				control2[7:1] <= wr_data[7:1];
			if (capture_evt)
				control2[cause_flag_pos] <= 1'b1;
			else if (reload_evt)
				control2[cause_flag_pos] <= 1'b0;
		end
	end

	// ********************
	// Counter and capture
	// ********************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count   <= count_reset;
			capture <= 16'h0000;
		end
		else
		begin
			if (capture_evt)
				capture <= count;
			if (capture_evt)
				count <= restart_count;
			else if (reload_evt)
				count <= restart_count;
			else if (running && tick)
				count <= count + 16'h0001;
			else if (we_count)
				count <= merge16(count, wr_data, wr_strb);
		end
	end

	// ********************
	// Interrupt status
	// ********************
	wire [1:0] irq_set = {reload_evt && rel_irq_ok,
		capture_evt && cap_irq_ok};
	wire [1:0] irq_clr = we_status ? wr_data[1:0] : 2'h0;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_status <= 2'h0;
		else
			irq_status <= (irq_status & ~irq_clr) | irq_set;
	end

	assign irq = |(irq_status & irq_mask);

	// ********************
	// AXI4-Lite read path
	// ********************
	assign s_axi_arready = !s_axi_rvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;

	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			control_offset:    rd_mux = {24'h000000, control};
			control2_offset:   rd_mux = {24'h000000, control2};
			count_offset:      rd_mux = {16'h0000, count};
			reload_offset:     rd_mux = {16'h0000, reload};
			capture_offset:    rd_mux = {16'h0000, capture};
			irq_status_offset: rd_mux = {30'h0, irq_status};
			irq_mask_offset:   rd_mux = {30'h0, irq_mask};
			default:
			begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= axi_okay;
		end
		else if (ar_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? axi_okay : axi_slverr;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule : timer_capture_restart

// >>> logic/capture_timer_pkg.sv
// Constants for the capture-restart timer and its register slave
package capture_timer_pkg;
	// ********************
	// Register byte addresses
	// ********************
	localparam logic [7:0] control_offset     = 8'h00;
	localparam logic [7:0] control2_offset    = 8'h04;
	localparam logic [7:0] count_offset       = 8'h08;
	localparam logic [7:0] reload_offset      = 8'h0c;
	localparam logic [7:0] capture_offset     = 8'h10;
	localparam logic [7:0] irq_status_offset  = 8'h14;
	localparam logic [7:0] irq_mask_offset    = 8'h18;

	// ********************
	// Control register fields
	// ********************
	localparam int enable_bit     = 7;
	localparam int polarity_bit   = 6;
	localparam int prescale_lsb   = 3;
	localparam int prescale_width = 3;
	localparam int mode_lsb       = 0;
	localparam int mode_width     = 3;

	// ********************
	// Second control register fields
	// ********************
	localparam int mode_upper_pos   = 7;
	localparam int source_sel_lsb   = 5;
	localparam int cause_flag_pos   = 0;

	// Full four-bit mode code of capture-restart
	localparam logic [3:0] mode_capture_restart = 4'h9;

	// Interrupt source select codes
	localparam logic [1:0] source_both    = 2'h0;
	localparam logic [1:0] source_capture = 2'h2;
	localparam logic [1:0] source_reload  = 2'h3;

	// Interrupt status bit positions
	localparam int irq_capture_pos = 0;
	localparam int irq_reload_pos  = 1;

	// ********************
	// Reset and restart values, bus response codes
	// ********************
	localparam logic [15:0] count_reset    = 16'h0000;
	localparam logic [15:0] reload_reset   = 16'hffff;
	localparam logic [15:0] restart_count  = 16'h0001;
	localparam logic [1:0]  axi_okay       = 2'h0;
	localparam logic [1:0]  axi_slverr     = 2'h2;
endpackage : capture_timer_pkg

// >>> logic/edge_detect.sv
// Selectable-polarity edge detector for the timer input pin
`timescale 1ns/1ns
module edge_detect
	import capture_timer_pkg::*;
(
	input  wire logic aclk,        // System clock
	input  wire logic aresetn,     // Synchronous reset, active low
	input  wire logic pin,         // Timer input level
	input  wire logic rising,      // 1 selects rising edges
	output wire logic edge_pulse   // One-cycle edge pulse
);
	logic last;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last <= 1'b0;
		else
			last <= pin;
	end

	assign edge_pulse = rising ? (pin & ~last) : (~pin & last);
endmodule : edge_detect

// >>> logic/prescaler.sv
// Power-of-two prescaler giving one tick per prescale period
`timescale 1ns/1ns
module prescaler
	import capture_timer_pkg::*;
#(
	parameter int WIDTH = 7
)
(
	input  wire logic       aclk,      // System clock
	input  wire logic       aresetn,   // Synchronous reset, active low
	input  wire logic       run,       // Count while high
	input  wire logic       restart,   // Restart the period
	input  wire logic [2:0] shift,     // Divide by 2**shift
	output wire logic       tick       // One-cycle tick per period
);
	logic [WIDTH-1:0] divider;
	wire  [WIDTH-1:0] limit = WIDTH'((1 << shift) - 1);

	assign tick = run && (divider == limit);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run || restart || tick)
			divider <= '0;
		else
			divider <= divider + WIDTH'(1);
	end
endmodule : prescaler

// >>> verification/pin_source.sv
// Signal source model standing on the timer input pin
`timescale 1ns/1ns
module pin_source
(
	input  wire logic       aclk,     // System clock
	input  wire logic       want,     // Requested pin level
	input  wire logic [3:0] lag,      // Cycles of delay before following
	output logic            timer_in  // Pin level
);
	logic [3:0] waited = 4'h0;
	initial timer_in = 1'b0;
	always @(posedge aclk)
	begin
		waited <= (want == timer_in) ? 4'h0 : waited + 4'h1;
		// Slow sources are modelled by a lag before the level follows
		if (want != timer_in && waited >= lag)
			timer_in <= want;
	end
endmodule : pin_source

// >>> verification/timer_capture_restart_checker.sv
// Bus and interrupt checker for the capture-restart timer
`timescale 1ns/1ns
module timer_capture_restart_checker
	import capture_timer_pkg::*;
(
	input wire logic        aclk,          // Clock
	input wire logic        aresetn,       // Reset, low
	input wire logic        s_axi_awready, // AW ready
	input wire logic        s_axi_wready,  // W ready
	input wire logic        s_axi_bvalid,  // B valid
	input wire logic        s_axi_bready,  // B ready
	input wire logic [7:0]  s_axi_araddr,  // AR address
	input wire logic        s_axi_arvalid, // AR valid
	input wire logic        s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata,   // R data
	input wire logic [1:0]  s_axi_rresp,   // R response
	input wire logic        s_axi_rvalid,  // R valid
	input wire logic        s_axi_rready,  // R ready
	input wire logic        irq            // Interrupt
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	chk_read_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	chk_write_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_unmapped_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
		|=> s_axi_rresp == axi_slverr && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_mapped_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h18
		&& s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == axi_okay)
		else $error("mapped read refused");
	chk_irq_sticky: assert property (
		$fell(irq) |-> $rose(s_axi_bvalid))
		else $error("interrupt dropped without a write");
endmodule : timer_capture_restart_checker

bind timer_capture_restart timer_capture_restart_checker chk_inst
(
	.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);

// >>> verification/timer_capture_restart_tb_top.sv
// Register-level testbench for the capture-restart timer
`timescale 1ns/1ns
module timer_capture_restart_tb_top
	import capture_timer_pkg::*;
;
	logic             aclk = 1'b0, aresetn = 1'b0, want = 1'b0;
	logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic             s_axi_rready = 1'b0;
	logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]      s_axi_wdata = 32'h0, v;
	logic [3:0]       s_axi_wstrb = 4'hf, lag = 4'h0;
	wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire logic        s_axi_arready, s_axi_rvalid, timer_in, irq;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int               num_errors = 0, cmp_count = 0;
	timer_capture_restart dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .timer_in, .irq
	);
	pin_source source
	(
		.aclk, .want, .lag, .timer_in
	);
	initial
	begin
		forever #5 aclk = ~aclk;
	end
	// ********************
	// Bus and check tasks
	// ********************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_up(input int n);
		if (n == 40)
		begin
			num_errors++;
			results();
		end
	endtask : give_up
	// Entry edge keeps a strobe from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = axi_okay);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		give_up(n);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er = axi_okay);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		give_up(n);
	endtask : rd
	task automatic cfg(input logic [7:0] ctl, input logic [7:0] ctl2,
		input logic [15:0] rl);
		wr(control_offset, {24'h0, ctl});
		wr(control2_offset, {24'h0, ctl2});
		wr(count_offset, 32'h1);
		wr(reload_offset, {16'h0, rl});
		wr(irq_status_offset, 32'h3);
		wr(irq_mask_offset, 32'h3);
		wr(control_offset, {24'h0, ctl | 8'h80});
	endtask : cfg
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			rd(8'(4 * i));
			chk(v, (i == 3) ? 32'hffff : 32'h0);
		end
		rd(8'h1c, axi_slverr);
		chk(v, 32'h0);
		wr(8'h1c, 32'h1, axi_slverr);
		wr(control_offset, 32'h41);
		wr(control2_offset, 32'h80);
		want <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(count_offset);
		chk(v, 32'h0);
		rd(irq_status_offset);
		chk(v, 32'h0);
		want <= 1'b0;
		$display("reset and disabled test done");
		// Divide by four, so the capture lands near six ticks
		cfg(8'h51, 8'h80, 16'hffff);
		repeat (20) @(posedge aclk);
		want <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(capture_offset);
		chk({31'h0, v >= 5 && v <= 8}, 32'h1);
		rd(irq_status_offset);
		chk(v, 32'h1);
		rd(control2_offset);
		chk(v, 32'h81);
		rd(count_offset);
		chk({31'h0, v >= 1 && v <= 4}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(reload_offset, 32'h10);
		repeat (80) @(posedge aclk);
		rd(control2_offset);
		chk(v, 32'h80);
		rd(irq_status_offset);
		chk(v, 32'h3);
		wr(irq_status_offset, 32'h1);
		wr(irq_mask_offset, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(irq_mask_offset, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(control_offset, 32'h51);
		wr(count_offset, 32'h5);
		wr(irq_status_offset, 32'h3);
		want <= 1'b0;
		repeat (6) @(posedge aclk);
		want <= 1'b1;
		repeat (20) @(posedge aclk);
		rd(count_offset);
		chk(v, 32'h5);
		rd(irq_status_offset);
		chk(v, 32'h0);
		$display("capture and reload test done");
		cfg(8'h01, 8'h80, 16'hffff);
		lag <= 4'h3;
		want <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(irq_status_offset);
		chk(v, 32'h1);
		wr(irq_status_offset, 32'h1);
		want <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(irq_status_offset);
		chk(v, 32'h0);
		$display("falling edge test done");
		want <= 1'b0;
		cfg(8'h41, 8'hc0, 16'h0008);
		repeat (30) @(posedge aclk);
		want <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(irq_status_offset);
		chk(v, 32'h1);
		cfg(8'h41, 8'he0, 16'h0008);
		want <= 1'b0;
		repeat (4) @(posedge aclk);
		want <= 1'b1;
		repeat (10) @(posedge aclk);
		rd(irq_status_offset);
		chk(v, 32'h2);
		$display("source select test done");
		results();
	end
endmodule : timer_capture_restart_tb_top
